/* shared/hbt_pkg.sv */
package hbt_pkg;

  // ------------------------------------------------------------------
  // Structure of the break and trace unit
  // ------------------------------------------------------------------
  localparam int HBT_NUM_CH = 8;         // Hardware break channels.
  localparam int HBT_NUM_DATA_CH = 2;    // Leading channels that also compare data.
  localparam int HBT_ADDR_W = 24;        // Processor address bus width.
  localparam int HBT_DATA_W = 16;        // Processor data bus width.
  localparam int HBT_TRACE_DEPTH = 16;   // Branch-source trace entries.

  // ------------------------------------------------------------------
  // Data lane positions
  // ------------------------------------------------------------------
  localparam int HBT_LO_LSB = 0;
  localparam int HBT_LO_MSB = 7;
  localparam int HBT_HI_LSB = 8;
  localparam int HBT_HI_MSB = 15;

  // ------------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------------
  // Access size of a bus cycle and of a data qualifier.
  typedef enum logic [1:0] {
    HBT_SZ_HIGH,
    HBT_SZ_LOW,
    HBT_SZ_WORD
  } hbt_size_t;

  // Execution mode requested by the debugger.
  typedef enum logic [2:0] {
    HBT_MODE_RUN,
    HBT_MODE_CURSOR,
    HBT_MODE_STEP_IN,
    HBT_MODE_STEP_OVER,
    HBT_MODE_STEP_OUT
  } hbt_mode_t;

  // Core control state seen by the unit.
  typedef enum logic {
    HBT_ST_RUN,
    HBT_ST_BREAK
  } hbt_state_t;

endpackage : hbt_pkg

/* logic/hbt_unit.sv */
`timescale 1ns/1ns

// Summary of operation
// - Eight hardware break channels are each configured on their own and can halt the core.
// - A channel matches when the address bus equals its programmed address.
// - Only channels 1 and 2 also compare the data bus; channels 3 to 8 never look at data.
// - The data compare is qualified by access size: high byte, low byte or whole word.
// - Every channel may be limited to read cycles only or to write cycles only.
// - Hardware channels sleep in cursor and step modes, and software breakpoints in step-over.
// - After a restart on a software breakpoint, a channel match on the first bus cycle is ignored.
// - The source address of every executed branch is written into trace storage in real time.
module hbt_unit
  import hbt_pkg::*;
#(
  parameter int NUM_CH = HBT_NUM_CH,
  parameter int NUM_DATA_CH = HBT_NUM_DATA_CH,
  parameter int ADDR_W = HBT_ADDR_W,
  parameter int DATA_W = HBT_DATA_W,
  parameter int TRACE_DEPTH = HBT_TRACE_DEPTH
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic bus_valid,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_data,
  input wire logic bus_write,
  input wire hbt_size_t bus_size,
  input wire logic [NUM_CH-1:0] ch_enable,
  input wire logic [NUM_CH*ADDR_W-1:0] ch_addr,
  input wire logic [NUM_CH-1:0] ch_dir_en,
  input wire logic [NUM_CH-1:0] ch_dir_write,
  input wire logic [NUM_DATA_CH-1:0] ch_data_en,
  input wire logic [NUM_DATA_CH*DATA_W-1:0] ch_data,
  input wire logic [NUM_DATA_CH*2-1:0] ch_size,
  input wire hbt_mode_t exec_mode,
  input wire logic restart,
  input wire logic restart_on_swbp,
  input wire logic sw_bp_hit,
  input wire logic branch_valid,
  input wire logic [ADDR_W-1:0] branch_src,
  input wire logic [$clog2(TRACE_DEPTH)-1:0] trace_rd_idx,
  output logic halt_q,
  output logic [NUM_CH-1:0] break_ch_q,
  output logic sw_bp_enable_q,
  output logic [ADDR_W-1:0] trace_rd_data_q,
  output logic [$clog2(TRACE_DEPTH):0] trace_count_q
);

  localparam int PTR_W = $clog2(TRACE_DEPTH);
  localparam logic [PTR_W:0] TRACE_FULL = (PTR_W + 1)'(TRACE_DEPTH);

  hbt_state_t state_q;
  logic suppress_q;
  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] data_ok;
  logic [ADDR_W-1:0] ch_addr_w [NUM_CH];
  logic hw_armed;
  logic sw_break;
  logic hw_break;
  logic [ADDR_W-1:0] trace_mem [TRACE_DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;

  // ------------------------------------------------------------------
  // Channel comparators
  // ------------------------------------------------------------------
  // One comparator per channel; data lanes exist only on the leading channels.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic addr_ok;
    logic dir_ok;
    assign ch_addr_w[i] = ch_addr[i*ADDR_W +: ADDR_W];
    assign addr_ok = (bus_addr == ch_addr_w[i]);
    assign dir_ok = !ch_dir_en[i] || (bus_write == ch_dir_write[i]);
    if (i < NUM_DATA_CH) begin : g_data
      logic [DATA_W-1:0] ref_data;
      hbt_size_t ref_size;
      logic lanes_ok;
      assign ref_data = ch_data[i*DATA_W +: DATA_W];
      assign ref_size = hbt_size_t'(ch_size[i*$bits(hbt_size_t) +: $bits(hbt_size_t)]);
      // The bus cycle must carry the selected size, then only its lanes are compared.
      always_comb begin
        case (ref_size)
          HBT_SZ_HIGH: lanes_ok = bus_data[HBT_HI_MSB:HBT_HI_LSB] ==
                                  ref_data[HBT_HI_MSB:HBT_HI_LSB];
          HBT_SZ_LOW: lanes_ok = bus_data[HBT_LO_MSB:HBT_LO_LSB] ==
                                 ref_data[HBT_LO_MSB:HBT_LO_LSB];
          default: lanes_ok = (bus_data == ref_data);
        endcase
      end
      assign data_ok[i] = !ch_data_en[i] || ((bus_size == ref_size) && lanes_ok);
    end else begin : g_nodata
      assign data_ok[i] = 1'b1;
      // Whatever the data bus carries, an address and direction match must break here.
      data_free_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (hw_armed && bus_valid && ch_enable[i] && addr_ok && dir_ok) |=> break_ch_q[i])
        else $error("data compare active on an address-only channel");
    end
    assign hit[i] = bus_valid && ch_enable[i] && addr_ok && dir_ok && data_ok[i];

    chan_hit_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (hw_armed && hit[i]) |=> break_ch_q[i]) else $error("channel match not recorded");
    addr_equal_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $rose(break_ch_q[i]) |-> $past(bus_addr) == $past(ch_addr_w[i]))
      else $error("break recorded without address equality");
    dir_qual_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ($rose(break_ch_q[i]) && $past(ch_dir_en[i])) |->
      $past(bus_write) == $past(ch_dir_write[i]))
      else $error("break on wrong direction");
  end

  // ------------------------------------------------------------------
  // Break arming
  // ------------------------------------------------------------------
  // Channels are armed only in free run and never up to and on the first bus cycle after a breakpoint restart.
  assign hw_armed = (state_q == HBT_ST_RUN) && (exec_mode == HBT_MODE_RUN)
                    && !suppress_q;
  assign hw_break = hw_armed && (|hit);
  assign sw_break = (state_q == HBT_ST_RUN) && sw_bp_hit && (exec_mode != HBT_MODE_STEP_OVER);

  // Suppression lasts until the first bus cycle after a breakpoint restart, so a slow
  // first fetch cannot reopen the window.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      suppress_q <= 1'b0;
    end else if (restart && restart_on_swbp) begin
      suppress_q <= 1'b1;
    end else if (bus_valid) begin
      suppress_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Run and break control
  // ------------------------------------------------------------------
  // A restart leaves the break state; matches are only taken while running.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= HBT_ST_RUN;
      halt_q <= 1'b0;
      break_ch_q <= '0;
    end else begin
      case (state_q)
        HBT_ST_RUN: begin
          if (hw_break || sw_break) begin
            state_q <= HBT_ST_BREAK;
            halt_q <= 1'b1;
            break_ch_q <= hw_break ? hit : '0;
          end
        end
        HBT_ST_BREAK: begin
          if (restart) begin
            state_q <= HBT_ST_RUN;
            halt_q <= 1'b0;
            break_ch_q <= '0;
          end
        end
        default: state_q <= HBT_ST_RUN;
      endcase
    end
  end

  // Software breakpoints are disabled while stepping over a call.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_bp_enable_q <= 1'b1;
    end else begin
      sw_bp_enable_q <= (exec_mode != HBT_MODE_STEP_OVER);
    end
  end

  halt_on_hit_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    hw_break |=> halt_q) else $error("qualified match did not halt");
  step_quiet_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ((exec_mode != HBT_MODE_RUN) && !sw_bp_hit && !halt_q) |=> !halt_q)
    else $error("hardware break taken in a step mode");
  stepover_swbp_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (exec_mode == HBT_MODE_STEP_OVER) |=> !sw_bp_enable_q ##0 (!$rose(halt_q)))
    else $error("software breakpoint live in step-over");
  // The mask may wait several idle cycles for the first bus cycle, so it is watched
  // through its own flag rather than at a fixed distance from the restart.
  restart_mask_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (suppress_q && !halt_q && bus_valid && !sw_bp_hit) |=> !halt_q)
    else $error("break on first cycle after breakpoint restart");
  mask_arm_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (restart && restart_on_swbp) |=> suppress_q) else $error("restart mask not armed");

  // ------------------------------------------------------------------
  // Branch trace
  // ------------------------------------------------------------------
  // Circular store: the oldest entry is overwritten, the count saturates at depth.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      trace_count_q <= '0;
    end else if (branch_valid) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
      if (trace_count_q != TRACE_FULL) begin
        trace_count_q <= trace_count_q + 1'b1;
      end
    end
  end

  // Storage has no reset so it maps onto plain memory.
  always_ff @(posedge ref_clk) begin
    if (branch_valid) begin
      trace_mem[wr_ptr_q] <= branch_src;
    end
  end

  // Registered read port for the debugger, one cycle of latency.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trace_rd_data_q <= '0;
    end else begin
      trace_rd_data_q <= trace_mem[trace_rd_idx];
    end
  end

  trace_store_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    branch_valid |=> trace_mem[$past(wr_ptr_q)] == $past(branch_src))
    else $error("branch source not stored");
  trace_count_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (branch_valid && trace_count_q != TRACE_FULL) |=> trace_count_q == $past(trace_count_q) + 1)
    else $error("trace count did not advance");

endmodule : hbt_unit

/* tb/hbt_emu_model.sv */
`timescale 1ns/1ns

// -----------------------------------------------------------------
// Debugger side of the break unit
// -----------------------------------------------------------------
module hbt_emu_model (
  input wire logic ref_clk,
  input wire logic halt_q,
  input wire logic [23:0] bp_req,
  output logic restart,
  output logic tck,
  output logic [23:0] bp_addr,
  output logic [31:0] stack_pointer_register,
  output logic [7:0] extended_control_register
);
  localparam logic [31:0] SP_START = 32'h00000010;
  localparam logic [7:0] EXT_CTRL_START = 8'h7f;
  logic [1:0] wait_q = 2'h0;
  logic [1:0] tck_div_q = 2'h0;
  logic restart_q = 1'b0;

  // Register image loaded when the debugger starts up.
  assign stack_pointer_register = SP_START;
  assign extended_control_register = EXT_CTRL_START;

  // Breakpoints replace whole instructions on word boundaries, so bit 0 is dropped.
  assign bp_addr = {bp_req[23:1], 1'b0};

  // Test clock at a quarter of the system rate; a faster one would outrun the port.
  always @(negedge ref_clk) begin
    tck_div_q <= tck_div_q + 2'h1;
  end
  assign tck = tck_div_q[1];

  // Two halted cycles stand for saving and restoring system control state.
  always @(negedge ref_clk) begin
    wait_q <= halt_q ? wait_q + 2'h1 : 2'h0;
    restart_q <= halt_q && (wait_q == 2'h2);
  end
  assign restart = restart_q;
endmodule : hbt_emu_model

/* tb/hbt_tb_top.sv */
`timescale 1ns/1ns

module hardware_break_trace_unit_tb_top;
  import hbt_pkg::*;
  logic ref_clk = 1'b0, arst_n = 1'b0, bus_valid = 1'b0, bus_write = 1'b0;
  logic restart_on_swbp = 1'b0, sw_bp_hit = 1'b0, branch_valid = 1'b0;
  logic [23:0] bus_addr = '0, branch_src = '0;
  logic [15:0] bus_data = '0;
  hbt_size_t bus_size = HBT_SZ_WORD;
  hbt_mode_t exec_mode = HBT_MODE_RUN;
  logic [7:0] ch_enable = '0, ch_dir_en = '0, ch_dir_write = '0;
  logic [191:0] ch_addr = '0;
  logic [1:0] ch_data_en = '0;
  logic [31:0] ch_data = '0;
  logic [3:0] ch_size = '0, trace_rd_idx = '0;
  logic restart, halt_q, sw_bp_enable_q, tck;
  logic [23:0] bp_req = '0, bp_addr;
  logic [31:0] stack_pointer_register;
  logic [7:0] extended_control_register;
  logic [7:0] break_ch_q;
  logic [23:0] trace_rd_data_q;
  logic [4:0] trace_count_q;
  int num_errors = 0, n_compared = 0;

  hbt_unit u_dut (
    .ref_clk, .arst_n, .bus_valid, .bus_addr, .bus_data, .bus_write, .bus_size, .ch_enable,
    .ch_addr, .ch_dir_en, .ch_dir_write, .ch_data_en, .ch_data, .ch_size, .exec_mode, .restart,
    .restart_on_swbp, .sw_bp_hit, .branch_valid, .branch_src, .trace_rd_idx, .halt_q,
    .break_ch_q, .sw_bp_enable_q, .trace_rd_data_q, .trace_count_q
  );
  hbt_emu_model u_emu (
    .ref_clk, .halt_q, .bp_req, .restart, .tck, .bp_addr, .stack_pointer_register,
    .extended_control_register
  );

  // Free-running system clock, 40 ns period.
  initial forever #20 ref_clk = ~ref_clk;

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    n_compared++;
    if (e !== g) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Waits for the debugger to resume; a hung break ends the run.
  task automatic wait_run();
    for (int i = 0; i < 10 && halt_q !== 1'b0; i++) @(negedge ref_clk);
    if (halt_q !== 1'b0) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : wait_run

  // One bus cycle, then the break outcome one cycle later.
  task automatic cyc(logic [23:0] a, logic [15:0] d, logic w, hbt_size_t s, logic [7:0] e);
    @(negedge ref_clk);
    {bus_valid, bus_addr, bus_data, bus_write, bus_size} = {1'b1, a, d, w, s};
    @(negedge ref_clk);
    bus_valid = 1'b0;
    chk("break_ch_q", {16'h0000, e}, {16'h0000, break_ch_q});
    chk("halt_q", {23'h000000, |e}, {23'h000000, halt_q});
    wait_run();
  endtask : cyc

  // Debugger start-up image and the pace of its test clock, sampled where it is settled.
  task automatic t_emu();
    logic last;
    int n_chg = 0;
    chk("stack_pointer_register", 24'h000010, stack_pointer_register[23:0]);
    chk("extended_control_register", 24'h00007f,
        {16'h0000, extended_control_register});
    @(posedge ref_clk);
    last = tck;
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      n_chg += int'(tck !== last);
      last = tck;
    end
    chk("tck slower than ref_clk", 24'h000001, {23'h000000, n_chg inside {[1:4]}});
    $display("test emu done");
  endtask : t_emu

  task automatic t_addr();
    for (int k = 0; k < 8; k++) begin
      ch_enable = 8'h01 << k;
      ch_addr[k*24 +: 24] = 24'h00a000 + 24'(k * 2);
      cyc(24'h00a001 + 24'(k * 2), 16'h0000, 1'b0, HBT_SZ_WORD, 8'h00);
      cyc(24'h00a000 + 24'(k * 2), 16'h0000, 1'b0, HBT_SZ_WORD, ch_enable);
    end
    $display("test addr done");
  endtask : t_addr

  task automatic t_data();
    ch_enable = 8'h01;
    ch_addr[23:0] = 24'h002000;
    ch_data_en = 2'h1;
    ch_data[15:0] = 16'h5aa5;
    ch_size[1:0] = HBT_SZ_HIGH;
    cyc(24'h002000, 16'h5a00, 1'b0, HBT_SZ_HIGH, 8'h01);
    cyc(24'h002000, 16'h5b00, 1'b0, HBT_SZ_HIGH, 8'h00);
    cyc(24'h002000, 16'h5aa5, 1'b0, HBT_SZ_LOW, 8'h00);
    ch_size[1:0] = HBT_SZ_LOW;
    cyc(24'h002000, 16'h00a5, 1'b0, HBT_SZ_LOW, 8'h01);
    ch_size[1:0] = HBT_SZ_WORD;
    cyc(24'h002000, 16'h5aa4, 1'b0, HBT_SZ_WORD, 8'h00);
    cyc(24'h002000, 16'h5aa5, 1'b0, HBT_SZ_WORD, 8'h01);
    ch_enable = 8'h05;
    ch_addr[71:48] = 24'h002000;
    cyc(24'h002000, 16'h1234, 1'b0, HBT_SZ_WORD, 8'h04);
    ch_data_en = 2'h0;
    $display("test data done");
  endtask : t_data

  task automatic t_dir();
    ch_enable = 8'h01;
    ch_dir_en = 8'h01;
    ch_dir_write = 8'h01;
    cyc(24'h002000, 16'h0000, 1'b0, HBT_SZ_WORD, 8'h00);
    cyc(24'h002000, 16'h0000, 1'b1, HBT_SZ_WORD, 8'h01);
    ch_dir_write = 8'h00;
    cyc(24'h002000, 16'h0000, 1'b1, HBT_SZ_WORD, 8'h00);
    cyc(24'h002000, 16'h0000, 1'b0, HBT_SZ_WORD, 8'h01);
    ch_dir_en = 8'h00;
    $display("test dir done");
  endtask : t_dir

  // Software breakpoint pulse, expected halt seen one cycle on.
  task automatic swbp(logic e);
    @(negedge ref_clk);
    sw_bp_hit = 1'b1;
    @(negedge ref_clk);
    sw_bp_hit = 1'b0;
    chk("sw halt_q", {23'h000000, e}, {23'h000000, halt_q});
  endtask : swbp

  task automatic t_mode();
    for (int m = 1; m < 5; m++) begin
      exec_mode = hbt_mode_t'(m);
      cyc(24'h002000, 16'h0000, 1'b0, HBT_SZ_WORD, 8'h00);
    end
    exec_mode = HBT_MODE_STEP_OVER;
    @(negedge ref_clk);
    chk("sw_bp_enable_q", 24'h000000, {23'h000000, sw_bp_enable_q});
    swbp(1'b0);
    exec_mode = HBT_MODE_RUN;
    @(negedge ref_clk);
    chk("sw_bp_enable_q", 24'h000001, {23'h000000, sw_bp_enable_q});
    $display("test mode done");
  endtask : t_mode

  task automatic t_resume();
    bp_req = 24'h002001;
    swbp(1'b1);
    chk("bp_addr", 24'h002000, bp_addr);
    chk("sw break_ch_q", 24'h000000, {16'h0000, break_ch_q});
    restart_on_swbp = 1'b1;
    wait_run();
    restart_on_swbp = 1'b0;
    cyc(bp_addr, 16'h0000, 1'b0, HBT_SZ_WORD, 8'h00);
    cyc(bp_addr, 16'h0000, 1'b0, HBT_SZ_WORD, 8'h01);
    $display("test resume done");
  endtask : t_resume

  // Seventeen back-to-back branches wrap over slot zero.
  task automatic t_trace();
    for (int i = 0; i < 17; i++) begin
      @(negedge ref_clk);
      {branch_valid, branch_src} = {1'b1, 24'h300000 + 24'(i)};
    end
    @(negedge ref_clk);
    branch_valid = 1'b0;
    chk("trace_count_q", 24'h000010, {19'h00000, trace_count_q});
    for (int i = 0; i < 2; i++) begin
      trace_rd_idx = 4'(i);
      @(negedge ref_clk);
      chk("trace_rd_data_q", i ? 24'h300001 : 24'h300010, trace_rd_data_q);
    end
    $display("test trace done");
  endtask : t_trace

  // Main sequence after five reset cycles.
  initial begin
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    chk("reset sw_bp_enable_q", 24'h000001, {23'h000000, sw_bp_enable_q});
    t_emu();
    t_addr();
    t_data();
    t_dir();
    t_mode();
    t_resume();
    t_trace();
    tally_and_finish();
  end
endmodule : hardware_break_trace_unit_tb_top
